/* verilog/tcw_consts.svh */
// Constants for the timer group: register indices, field positions,
// write masks and reset values. Included by every design file except the package.
`ifndef TCW_CONSTS_SVH
`define TCW_CONSTS_SVH
`define TCW_ADDR_TIMER0_CONTROL 4'h0
`define TCW_ADDR_TIMER0_COUNT_CONSTANT 4'h1
`define TCW_ADDR_TIMER1_CONTROL 4'h2
`define TCW_ADDR_TIMER1_COUNT_CONSTANT 4'h3
`define TCW_ADDR_REALTIME_TICK_CONTROL 4'h4
`define TCW_ADDR_WATCHDOG_COUNTER 4'h5
`define TCW_ADDR_WATCHDOG_CONTROL 4'h6
`define TCW_ADDR_IRQ_REQUEST_A 4'h7
`define TCW_ADDR_IRQ_REQUEST_B 4'h8
`define TCW_ADDR_IRQ_ENABLE_B 4'h9
`define TCW_RUN_BIT 7
`define TCW_MINUTE_BIT 6
`define TCW_WD_ACTION_BIT 6
`define TCW_WD_CLEAR_BIT 3
`define TCW_IRQ_TIMER_BIT 6
`define TCW_IRQ_CLOCK_BIT 4
`define TCW_IT_CTRL_MASK 8'h87
`define TCW_RT_CTRL_MASK 8'hc0
`define TCW_WD_CTRL_MASK 8'hc7
`define TCW_IRQ_A_MASK 8'h40
`define TCW_IRQ_B_MASK 8'h50
`define TCW_IRQ_EN_B_MASK 8'h10
`define TCW_BYTE_RESET 8'h00
`define TCW_PRESCALE_RESET 16'h0000
`define TCW_MAIN_PRESCALE_TAP_10_MASK 16'h07ff
`define TCW_SUB_CLOCK_HZ 32768
`define TCW_SECOND_LAST 6'h3b
`endif

/* verilog/tcw_pkg.sv */
// Types shared by the timer group: byte and count-clock selections.
// Assumes nothing of its surroundings.
package tcw_pkg;
    typedef logic [7:0] tcw_byte_t;
    typedef enum logic [2:0] {
        TCW_IT_DIV2 = 3'b000, TCW_IT_DIV1K = 3'b001, TCW_IT_DIV2K = 3'b010,
        TCW_IT_DIV4K = 3'b011, TCW_IT_DIV8K = 3'b100, TCW_IT_DIV16K = 3'b101,
        TCW_IT_DIV32K = 3'b110, TCW_IT_DIV64K = 3'b111
    } tcw_it_sel_t;
    typedef enum logic [2:0] {
        TCW_WD_MAIN12 = 3'b000, TCW_WD_MAIN13 = 3'b001, TCW_WD_MAIN14 = 3'b010,
        TCW_WD_MAIN15 = 3'b011, TCW_WD_SUB5 = 3'b100, TCW_WD_SUB6 = 3'b101,
        TCW_WD_SUB7 = 3'b110, TCW_WD_SUB8 = 3'b111
    } tcw_wd_sel_t;
endpackage

/* verilog/tcw_interval_timer.sv */
// One 8-bit interval timer with compare-match toggle output.
// Assumes a free-running main prescaler vector from the parent.
`timescale 1ns/1ns
`include "tcw_consts.svh"
module tcw_interval_timer (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic run,
    input wire tcw_pkg::tcw_it_sel_t clk_sel,
    input wire logic [15:0] main_prescale,
    input wire logic prescale_adv,
    input wire logic const_write,
    input wire tcw_pkg::tcw_byte_t const_data,
    output tcw_pkg::tcw_byte_t count,
    output logic toggle_out,
    output logic match_pulse
);
    logic [15:0] tap_mask;
    logic tick;
    tcw_pkg::tcw_byte_t count_reg, count_next, const_reg, const_next;
    logic out_reg, out_next, match_reg, match_next;

    always_comb begin
        unique case (clk_sel)
            tcw_pkg::TCW_IT_DIV2: tap_mask = 16'h0001;
            tcw_pkg::TCW_IT_DIV1K: tap_mask = 16'h03ff;
            tcw_pkg::TCW_IT_DIV2K: tap_mask = 16'h07ff;
            tcw_pkg::TCW_IT_DIV4K: tap_mask = 16'h0fff;
            tcw_pkg::TCW_IT_DIV8K: tap_mask = 16'h1fff;
            tcw_pkg::TCW_IT_DIV16K: tap_mask = 16'h3fff;
            tcw_pkg::TCW_IT_DIV32K: tap_mask = 16'h7fff;
            tcw_pkg::TCW_IT_DIV64K: tap_mask = 16'hffff;
        endcase
        // Prescaler frozen in stop state, so no tick then
        tick = prescale_adv && ((main_prescale & tap_mask) == tap_mask);
        const_next = const_write ? const_data : const_reg;
        count_next = count_reg;
        out_next = out_reg;
        match_next = 1'b0;
        if (run && tick) begin
            if (count_reg == const_reg) begin
                count_next = 8'h00;
                out_next = ~out_reg;
                match_next = 1'b1;
            end else begin
                count_next = count_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= `TCW_BYTE_RESET;
            const_reg <= `TCW_BYTE_RESET;
            out_reg <= 1'b0;
            match_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            const_reg <= const_next;
            out_reg <= out_next;
            match_reg <= match_next;
        end
    end

    assign count = count_reg;
    assign toggle_out = out_reg;
    assign match_pulse = match_reg;
endmodule

/* verilog/tcw_clock_timer.sv */
// Real-time clock timer: sub-clock edges to seconds, 1 s or 1 min event.
// Assumes one-cycle sub-clock edge pulses from the parent.
`timescale 1ns/1ns
`include "tcw_consts.svh"
module tcw_clock_timer #(
    parameter int SUB_PER_SECOND = `TCW_SUB_CLOCK_HZ
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic sub_edge,
    input wire logic run,
    input wire logic minute_mode,
    output logic [5:0] seconds,
    output logic period_pulse
);
    localparam logic [15:0] DIV_LAST = 16'(SUB_PER_SECOND - 1);
    logic [15:0] div_reg, div_next;
    logic [5:0] sec_reg, sec_next;
    logic pulse_reg, pulse_next;

    always_comb begin
        div_next = div_reg;
        sec_next = sec_reg;
        pulse_next = 1'b0;
        if (!run) begin
            div_next = 16'h0000;
            sec_next = 6'h00;
        end else if (sub_edge) begin
            if (div_reg == DIV_LAST) begin
                div_next = 16'h0000;
                if (sec_reg == `TCW_SECOND_LAST) begin
                    sec_next = 6'h00;
                    pulse_next = 1'b1;
                end else begin
                    sec_next = sec_reg + 6'h01;
                    pulse_next = !minute_mode;
                end
            end else begin
                div_next = div_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            div_reg <= 16'h0000;
            sec_reg <= 6'h00;
            pulse_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            sec_reg <= sec_next;
            pulse_reg <= pulse_next;
        end
    end

    assign seconds = sec_reg;
    assign period_pulse = pulse_reg;
endmodule

/* verilog/tcw_top.sv */
// Timer group top: two interval timers, clock timer, watchdog, registers.
// Assumes a simple strobe register port and a synchronous sub-clock input.
//
// Summary of operation
// - Two independent 8-bit prescaled up-counting timers
// - Control bit 7 runs; bits 6..3 zero
// - Bits 2..0 pick main clock divider
// - Data read gives count; write loads constant
// - Reset clears control and data registers
// - Output toggles when count equals constant
// - Clock timer gives 1 s or 1 min
// - Bit 7 runs counter; bit 6 picks minute
// - Bits 5..0 show seconds; writes ignored
// - Watchdog prescaler clears on reset, stop, clear
// - Watchdog prescaler divides tap 10 into 11..15
// - Watchdog counter 8-bit, read only, counts up
// - Bit 7 starts watchdog; clear zeroes, keeps running
// - Overflow gives reset or non-maskable interrupt
// - Bit 3 write-one clears; bits 5,4 zero
// - Bits 2..0 pick main or sub tap
// - Stop state halts main-clock timers only
// - Interval timers set request bit 6
// - Clock event sets request, enable bit 4
`timescale 1ns/1ns
`include "tcw_consts.svh"
module tcw_top #(
    parameter int SUB_PER_SECOND = `TCW_SUB_CLOCK_HZ
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [3:0] bus_addr,
    input wire tcw_pkg::tcw_byte_t bus_wdata,
    input wire logic bus_write,
    input wire logic bus_read,
    output tcw_pkg::tcw_byte_t bus_rdata,
    input wire logic sub_clk,
    input wire logic stop_mode,
    output logic timer0_out,
    output logic timer1_out,
    output logic timer0_irq_bit,
    output logic timer1_irq_bit,
    output logic clock_irq,
    output logic watchdog_reset,
    output logic watchdog_nmi
);
    // Shared main prescaler and sub-clock divider
    logic [15:0] main_prescale_reg, main_prescale_next;
    logic main_adv;
    logic sub_prev_reg, sub_prev_next;
    logic sub_edge;
    logic [7:0] sub_div_reg, sub_div_next;
    logic main_prescale_tap_10;

    // Control registers
    tcw_pkg::tcw_byte_t timer0_control_reg, timer0_control_next;
    tcw_pkg::tcw_byte_t timer1_control_reg, timer1_control_next;
    tcw_pkg::tcw_byte_t realtime_tick_control_reg, realtime_tick_control_next;
    tcw_pkg::tcw_byte_t watchdog_control_reg, watchdog_control_next;

    // Watchdog state
    logic [4:0] watchdog_prescaler_reg, watchdog_prescaler_next;
    tcw_pkg::tcw_byte_t watchdog_counter_reg, watchdog_counter_next;
    logic watchdog_run;
    logic watchdog_overflow_action;
    logic watchdog_clear_strobe;
    tcw_pkg::tcw_wd_sel_t watchdog_clock_select;
    logic [4:0] wd_main_mask;
    logic [7:0] wd_sub_mask;
    logic wd_from_sub;
    logic wd_tick;
    logic wd_overflow;
    logic wd_reset_reg, wd_reset_next;
    logic wd_nmi_reg, wd_nmi_next;

    // Interrupt request and enable bits
    tcw_pkg::tcw_byte_t irq_request_reg_a, irq_request_next_a;
    tcw_pkg::tcw_byte_t irq_request_reg_b, irq_request_next_b;
    tcw_pkg::tcw_byte_t irq_enable_reg_b, irq_enable_next_b;
    logic clock_irq_reg, clock_irq_next;

    // Read data
    tcw_pkg::tcw_byte_t rdata_reg, rdata_next;

    // Sub-block outputs
    tcw_pkg::tcw_byte_t t0_count, t1_count;
    logic t0_match, t1_match;
    logic [5:0] rt_seconds;
    logic rt_pulse;

    // Write decodes
    logic wr_t0c, wr_t0d, wr_t1c, wr_t1d, wr_rtc, wr_wdc;
    logic wr_ira, wr_irb, wr_ieb;

    always_comb begin
        wr_t0c = bus_write && (bus_addr == `TCW_ADDR_TIMER0_CONTROL);
        wr_t0d = bus_write && (bus_addr == `TCW_ADDR_TIMER0_COUNT_CONSTANT);
        wr_t1c = bus_write && (bus_addr == `TCW_ADDR_TIMER1_CONTROL);
        wr_t1d = bus_write && (bus_addr == `TCW_ADDR_TIMER1_COUNT_CONSTANT);
        wr_rtc = bus_write && (bus_addr == `TCW_ADDR_REALTIME_TICK_CONTROL);
        wr_wdc = bus_write && (bus_addr == `TCW_ADDR_WATCHDOG_CONTROL);
        wr_ira = bus_write && (bus_addr == `TCW_ADDR_IRQ_REQUEST_A);
        wr_irb = bus_write && (bus_addr == `TCW_ADDR_IRQ_REQUEST_B);
        wr_ieb = bus_write && (bus_addr == `TCW_ADDR_IRQ_ENABLE_B);
    end

    // Prescalers: main one freezes in stop state, sub-clock one never does
    always_comb begin
        main_adv = !stop_mode;
        main_prescale_next = main_adv ? main_prescale_reg + 16'h0001 : main_prescale_reg;
        sub_prev_next = sub_clk;
        sub_edge = sub_clk && !sub_prev_reg;
        sub_div_next = sub_edge ? sub_div_reg + 8'h01 : sub_div_reg;
        main_prescale_tap_10 = main_adv
            && ((main_prescale_reg & `TCW_MAIN_PRESCALE_TAP_10_MASK) == `TCW_MAIN_PRESCALE_TAP_10_MASK);
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            main_prescale_reg <= `TCW_PRESCALE_RESET;
            sub_prev_reg <= 1'b0;
            sub_div_reg <= `TCW_BYTE_RESET;
        end else begin
            main_prescale_reg <= main_prescale_next;
            sub_prev_reg <= sub_prev_next;
            sub_div_reg <= sub_div_next;
        end
    end

    // Control registers; bits that must be written as zero are not kept
    always_comb begin
        timer0_control_next = timer0_control_reg;
        timer1_control_next = timer1_control_reg;
        realtime_tick_control_next = realtime_tick_control_reg;
        watchdog_control_next = watchdog_control_reg;
        if (wr_t0c) begin
            timer0_control_next = bus_wdata & `TCW_IT_CTRL_MASK;
        end
        if (wr_t1c) begin
            timer1_control_next = bus_wdata & `TCW_IT_CTRL_MASK;
        end
        if (wr_rtc) begin
            realtime_tick_control_next = bus_wdata & `TCW_RT_CTRL_MASK;
        end
        if (wr_wdc) begin
            // Clear bit is a strobe only, never stored
            watchdog_control_next = bus_wdata & `TCW_WD_CTRL_MASK;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            timer0_control_reg <= `TCW_BYTE_RESET;
            timer1_control_reg <= `TCW_BYTE_RESET;
            realtime_tick_control_reg <= `TCW_BYTE_RESET;
            watchdog_control_reg <= `TCW_BYTE_RESET;
        end else begin
            timer0_control_reg <= timer0_control_next;
            timer1_control_reg <= timer1_control_next;
            realtime_tick_control_reg <= realtime_tick_control_next;
            watchdog_control_reg <= watchdog_control_next;
        end
    end

    // Watchdog
    always_comb begin
        watchdog_run = watchdog_control_reg[`TCW_RUN_BIT];
        watchdog_overflow_action = watchdog_control_reg[`TCW_WD_ACTION_BIT];
        watchdog_clock_select = tcw_pkg::tcw_wd_sel_t'(watchdog_control_reg[2:0]);
        watchdog_clear_strobe = wr_wdc && bus_wdata[`TCW_WD_CLEAR_BIT];
        wd_main_mask = 5'h00;
        wd_sub_mask = 8'h00;
        wd_from_sub = 1'b0;
        unique case (watchdog_clock_select)
            tcw_pkg::TCW_WD_MAIN12: wd_main_mask = 5'h03;
            tcw_pkg::TCW_WD_MAIN13: wd_main_mask = 5'h07;
            tcw_pkg::TCW_WD_MAIN14: wd_main_mask = 5'h0f;
            tcw_pkg::TCW_WD_MAIN15: wd_main_mask = 5'h1f;
            tcw_pkg::TCW_WD_SUB5: begin
                wd_sub_mask = 8'h1f;
                wd_from_sub = 1'b1;
            end
            tcw_pkg::TCW_WD_SUB6: begin
                wd_sub_mask = 8'h3f;
                wd_from_sub = 1'b1;
            end
            tcw_pkg::TCW_WD_SUB7: begin
                wd_sub_mask = 8'h7f;
                wd_from_sub = 1'b1;
            end
            tcw_pkg::TCW_WD_SUB8: begin
                wd_sub_mask = 8'hff;
                wd_from_sub = 1'b1;
            end
        endcase
        // Sub taps keep running in stop state; main taps cannot tick then
        if (wd_from_sub) begin
            wd_tick = sub_edge && ((sub_div_reg & wd_sub_mask) == wd_sub_mask);
        end else begin
            wd_tick = main_prescale_tap_10
                && ((watchdog_prescaler_reg & wd_main_mask) == wd_main_mask);
        end
        wd_overflow = 1'b0;
        watchdog_prescaler_next = watchdog_prescaler_reg;
        watchdog_counter_next = watchdog_counter_reg;
        if (!watchdog_run) begin
            watchdog_prescaler_next = 5'h00;
            watchdog_counter_next = 8'h00;
        end else if (watchdog_clear_strobe) begin
            watchdog_prescaler_next = 5'h00;
            watchdog_counter_next = 8'h00;
        end else begin
            if (main_prescale_tap_10) begin
                watchdog_prescaler_next = watchdog_prescaler_reg + 5'h01;
            end
            if (wd_tick) begin
                watchdog_counter_next = watchdog_counter_reg + 8'h01;
                wd_overflow = (watchdog_counter_reg == 8'hff);
            end
        end
        wd_reset_next = wd_overflow && !watchdog_overflow_action;
        wd_nmi_next = wd_overflow && watchdog_overflow_action;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            watchdog_prescaler_reg <= 5'h00;
            watchdog_counter_reg <= `TCW_BYTE_RESET;
            wd_reset_reg <= 1'b0;
            wd_nmi_reg <= 1'b0;
        end else begin
            watchdog_prescaler_reg <= watchdog_prescaler_next;
            watchdog_counter_reg <= watchdog_counter_next;
            wd_reset_reg <= wd_reset_next;
            wd_nmi_reg <= wd_nmi_next;
        end
    end

    // Request bits: a hardware set in the same cycle as a clear wins
    always_comb begin
        irq_request_next_a = irq_request_reg_a;
        irq_request_next_b = irq_request_reg_b;
        irq_enable_next_b = irq_enable_reg_b;
        if (wr_ira) begin
            irq_request_next_a = bus_wdata & `TCW_IRQ_A_MASK;
        end
        if (wr_irb) begin
            irq_request_next_b = bus_wdata & `TCW_IRQ_B_MASK;
        end
        if (wr_ieb) begin
            irq_enable_next_b = bus_wdata & `TCW_IRQ_EN_B_MASK;
        end
        if (t0_match) begin
            irq_request_next_a[`TCW_IRQ_TIMER_BIT] = 1'b1;
        end
        if (t1_match) begin
            irq_request_next_b[`TCW_IRQ_TIMER_BIT] = 1'b1;
        end
        if (rt_pulse) begin
            irq_request_next_b[`TCW_IRQ_CLOCK_BIT] = 1'b1;
        end
        clock_irq_next = irq_request_next_b[`TCW_IRQ_CLOCK_BIT]
            && irq_enable_next_b[`TCW_IRQ_CLOCK_BIT];
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_request_reg_a <= `TCW_BYTE_RESET;
            irq_request_reg_b <= `TCW_BYTE_RESET;
            irq_enable_reg_b <= `TCW_BYTE_RESET;
            clock_irq_reg <= 1'b0;
        end else begin
            irq_request_reg_a <= irq_request_next_a;
            irq_request_reg_b <= irq_request_next_b;
            irq_enable_reg_b <= irq_enable_next_b;
            clock_irq_reg <= clock_irq_next;
        end
    end

    // Read port; data stands one cycle after the strobe only
    always_comb begin
        rdata_next = 8'h00;
        if (bus_read) begin
            unique case (bus_addr)
                `TCW_ADDR_TIMER0_CONTROL: rdata_next = timer0_control_reg;
                `TCW_ADDR_TIMER0_COUNT_CONSTANT: rdata_next = t0_count;
                `TCW_ADDR_TIMER1_CONTROL: rdata_next = timer1_control_reg;
                `TCW_ADDR_TIMER1_COUNT_CONSTANT: rdata_next = t1_count;
                `TCW_ADDR_REALTIME_TICK_CONTROL: begin
                    rdata_next = {realtime_tick_control_reg[7:6], rt_seconds};
                end
                `TCW_ADDR_WATCHDOG_COUNTER: rdata_next = watchdog_counter_reg;
                `TCW_ADDR_WATCHDOG_CONTROL: rdata_next = watchdog_control_reg;
                `TCW_ADDR_IRQ_REQUEST_A: rdata_next = irq_request_reg_a;
                `TCW_ADDR_IRQ_REQUEST_B: rdata_next = irq_request_reg_b;
                `TCW_ADDR_IRQ_ENABLE_B: rdata_next = irq_enable_reg_b;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= `TCW_BYTE_RESET;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    tcw_interval_timer u_timer0 (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .run(timer0_control_reg[`TCW_RUN_BIT]),
        .clk_sel(tcw_pkg::tcw_it_sel_t'(timer0_control_reg[2:0])),
        .main_prescale(main_prescale_reg),
        .prescale_adv(main_adv),
        .const_write(wr_t0d),
        .const_data(bus_wdata),
        .count(t0_count),
        .toggle_out(timer0_out),
        .match_pulse(t0_match)
    );

    tcw_interval_timer u_timer1 (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .run(timer1_control_reg[`TCW_RUN_BIT]),
        .clk_sel(tcw_pkg::tcw_it_sel_t'(timer1_control_reg[2:0])),
        .main_prescale(main_prescale_reg),
        .prescale_adv(main_adv),
        .const_write(wr_t1d),
        .const_data(bus_wdata),
        .count(t1_count),
        .toggle_out(timer1_out),
        .match_pulse(t1_match)
    );

    tcw_clock_timer #(
        .SUB_PER_SECOND(SUB_PER_SECOND)
    ) u_clock_timer (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .sub_edge(sub_edge),
        .run(realtime_tick_control_reg[`TCW_RUN_BIT]),
        .minute_mode(realtime_tick_control_reg[`TCW_MINUTE_BIT]),
        .seconds(rt_seconds),
        .period_pulse(rt_pulse)
    );

    assign bus_rdata = rdata_reg;
    assign timer0_irq_bit = irq_request_reg_a[`TCW_IRQ_TIMER_BIT];
    assign timer1_irq_bit = irq_request_reg_b[`TCW_IRQ_TIMER_BIT];
    assign clock_irq = clock_irq_reg;
    assign watchdog_reset = wd_reset_reg;
    assign watchdog_nmi = wd_nmi_reg;
endmodule

/* verification/tcw_top_monitor.sv */
// Checker for the timer group top: register port and event outputs.
// Assumes a bind to tcw_top; sees its ports only.
`timescale 1ns/1ns
module tcw_top_monitor (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [3:0] bus_addr,
    input wire logic bus_write,
    input wire logic bus_read,
    input wire tcw_pkg::tcw_byte_t bus_rdata,
    input wire logic timer0_out,
    input wire logic timer0_irq_bit,
    input wire logic timer1_irq_bit,
    input wire logic watchdog_reset,
    input wire logic watchdog_nmi
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    rdata_idle_a: assert property (
        !$past(bus_read) |-> bus_rdata == 8'h00) else $error("read data not idle");
    ctrl_rsvd_a: assert property (
        $past(bus_read) && $past(bus_addr) inside {4'h0, 4'h2} |-> bus_rdata[6:3] == 4'h0)
        else $error("timer control reserved bits set");
    wd_ctrl_a: assert property (
        $past(bus_read) && $past(bus_addr) == 4'h6 |-> bus_rdata[5:3] == 3'h0)
        else $error("watchdog clear or reserved bit read back");
    nmi_pulse_a: assert property (
        watchdog_nmi |=> !watchdog_nmi) else $error("nmi longer than one cycle");
    rst_pulse_a: assert property (
        watchdog_reset |=> !watchdog_reset) else $error("reset pulse too long");
    wd_excl_a: assert property (
        !(watchdog_reset && watchdog_nmi)) else $error("both overflow actions");
    irq0_hold_a: assert property (
        timer0_irq_bit && !(bus_write && bus_addr == 4'h7) |=> timer0_irq_bit)
        else $error("timer0 request lost");
    irq1_hold_a: assert property (
        timer1_irq_bit && !(bus_write && bus_addr == 4'h8) |=> timer1_irq_bit)
        else $error("timer1 request lost");
    toggle_irq_a: assert property (
        $changed(timer0_out) |=> timer0_irq_bit) else $error("toggle without request");
    cover property ($changed(timer0_out));
    cover property ($rose(watchdog_nmi));
    cover property ($rose(watchdog_reset));
endmodule

/* verification/tcw_top_tb_top.sv */
// Self-checking bench for the timer group top.
// Assumes tcw_top and its checker are compiled before this file.
`timescale 1ns/1ns
module tcw_top_tb_top;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] bus_addr = 4'h0;
    tcw_pkg::tcw_byte_t bus_wdata = 8'h00;
    logic bus_write = 1'b0;
    logic bus_read = 1'b0;
    logic [1:0] sub_div = 2'h0;
    logic stop_mode = 1'b0;
    tcw_pkg::tcw_byte_t bus_rdata;
    logic timer0_out, timer1_out, timer0_irq_bit, timer1_irq_bit;
    logic clock_irq, watchdog_reset, watchdog_nmi;
    int fails = 0;
    int checks_done = 0;
    always #10 ref_clk = ~ref_clk;
    // Sub-clock at a quarter of main rate keeps the watchdog run short
    always @(posedge ref_clk) sub_div <= sub_div + 2'h1;
    tcw_top #(.SUB_PER_SECOND(4)) u_dut (.ref_clk(ref_clk), .nrst(nrst),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write),
        .bus_read(bus_read), .bus_rdata(bus_rdata), .sub_clk(sub_div[1]),
        .stop_mode(stop_mode), .timer0_out(timer0_out), .timer1_out(timer1_out),
        .timer0_irq_bit(timer0_irq_bit), .timer1_irq_bit(timer1_irq_bit),
        .clock_irq(clock_irq), .watchdog_reset(watchdog_reset), .watchdog_nmi(watchdog_nmi));
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input bit ok, input string msg);
        checks_done++;
        if (!ok) begin
            fails++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic wr(input int a, input tcw_pkg::tcw_byte_t d);
        @(posedge ref_clk);
        bus_addr <= a[3:0];
        bus_wdata <= d;
        bus_write <= 1'b1;
        @(posedge ref_clk);
        bus_write <= 1'b0;
    endtask
    task automatic rd(input int a, output tcw_pkg::tcw_byte_t v);
        @(posedge ref_clk);
        bus_addr <= a[3:0];
        bus_read <= 1'b1;
        @(posedge ref_clk);
        bus_read <= 1'b0;
        @(negedge ref_clk);
        v = bus_rdata;
    endtask
    task automatic rdc(input int a, input tcw_pkg::tcw_byte_t e);
        tcw_pkg::tcw_byte_t v;
        rd(a, v);
        chk(v === e, "register read");
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return timer0_out;
            1: return timer1_out;
            2: return clock_irq;
            3: return watchdog_reset;
            default: return watchdog_nmi;
        endcase
    endfunction
    task automatic wait_chg(input int s, input int lim, output int n);
        logic v;
        v = pick(s);
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
            if (n > lim) begin
                chk(1'b0, "wait timed out");
                close_out();
            end
        end while (pick(s) === v);
    endtask
    task automatic t_regs();
        for (int a = 0; a < 10; a++)
            rdc(a, 8'h00);
        rdc(4'hc, 8'h00);
        wr(0, 8'hff);
        rdc(0, 8'h87);
        wr(0, 8'h00);
        wr(6, 8'h3f);
        rdc(6, 8'h07);
        wr(6, 8'h00);
        wr(5, 8'h55);
        rdc(5, 8'h00);
        $display("t_regs done");
    endtask
    task automatic t_timer();
        int n;
        logic v;
        tcw_pkg::tcw_byte_t c;
        wr(1, 8'h03);
        rdc(1, 8'h00);
        wr(0, 8'h80);
        wait_chg(0, 50, n);
        wait_chg(0, 50, n);
        chk(n == 8, "timer0 period");
        @(posedge ref_clk);
        #1;
        chk(timer0_irq_bit === 1'b1, "timer0 request");
        stop_mode <= 1'b1;
        v = timer0_out;
        repeat (40) @(posedge ref_clk);
        chk(timer0_out === v, "stop state");
        stop_mode <= 1'b0;
        wr(0, 8'h00);
        rd(1, c);
        repeat (20) @(posedge ref_clk);
        rdc(1, c);
        wr(2, 8'h81);
        wait_chg(1, 3000, n);
        wait_chg(1, 3000, n);
        chk(n == 1024, "timer1 period");
        @(posedge ref_clk);
        #1;
        chk(timer1_irq_bit === 1'b1, "timer1 request");
        wr(2, 8'h00);
        $display("t_timer done");
    endtask
    task automatic t_clock();
        int n;
        wr(9, 8'h10);
        wr(4, 8'hbf);
        rdc(4, 8'h80);
        wait_chg(2, 40, n);
        rdc(4, 8'h81);
        wr(4, 8'h00);
        wr(8, 8'h00);
        wr(4, 8'hc0);
        wait_chg(2, 2000, n);
        chk(n > 940 && n < 980, "minute event");
        wr(4, 8'h00);
        wr(8, 8'h00);
        $display("t_clock done");
    endtask
    task automatic t_wdog(input logic act);
        int n;
        tcw_pkg::tcw_byte_t v;
        wr(6, {1'b1, act, 6'h04});
        repeat (400) @(posedge ref_clk);
        rd(5, v);
        chk(v > 8'h01 && v < 8'h05, "watchdog counts");
        wr(6, {1'b1, act, 6'h0c});
        rd(5, v);
        chk(v <= 8'h01, "watchdog clear");
        wait_chg(act ? 4 : 3, 33000, n);
        chk(n > 32500 && n < 32900, "overflow time");
        wr(6, {1'b0, act, 6'h04});
        rdc(5, 8'h00);
        // Main tap 12: first count lands within 8192 clocks, second not before 14337
        wr(6, 8'h80);
        repeat (8300) @(posedge ref_clk);
        rdc(5, 8'h01);
        wr(6, 8'h00);
        $display("t_wdog done");
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        t_regs();
        t_timer();
        t_clock();
        t_wdog(1'b1);
        t_wdog(1'b0);
        close_out();
    end
endmodule
bind tcw_top tcw_top_monitor u_mon (.ref_clk(ref_clk), .nrst(nrst), .bus_addr(bus_addr),
    .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
    .timer0_out(timer0_out), .timer0_irq_bit(timer0_irq_bit),
    .timer1_irq_bit(timer1_irq_bit), .watchdog_reset(watchdog_reset),
    .watchdog_nmi(watchdog_nmi));
